// file: logic/drm_ems_mem.sv
// Small memory holding extended mode register images
`timescale 1ns/10ps
module drm_ems_mem
   import drm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic [EMS_AW-1:0] i_wr_addr,
   input wire logic [EMS_W-1:0] i_wr_data,
   input wire logic [EMS_AW-1:0] i_rd_addr,
   output logic [EMS_W-1:0] o_rd_data
);
   logic [EMS_W-1:0] mem [EMS_N];  // Image storage
   logic [EMS_W-1:0] rd_data;      // Registered read port

   // Storage and registered read
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rd_data <= 16'h_0000;
         for (int i = 0; i < EMS_N; i++) begin
            mem[i] <= 16'h_0000;
         end
      end else begin
         rd_data <= mem[i_rd_addr];
         if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
         end
      end
   end

   assign o_rd_data = rd_data;
endmodule // drm_ems_mem

// file: logic/drm_pkg.sv
// Package of constants and types for the rank map and frequency change block
package drm_pkg;
   localparam int NUM_RANKS = 2;              // Two chip selects
   localparam int ADDR_W = 29;                // Cap on cs+bank+row+col bits
   localparam int DP_W = 2;                   // Datapath byte offset bits
   localparam int UADDR_W = 31;               // User address width
   localparam int MAX_ROW = 15;               // Largest row field
   localparam int MAX_COL = 13;               // Largest column field
   localparam int MAX_BANK = 3;               // Eight-bank field
   localparam int MSK_W = 16;                 // Match value and mask width
   localparam int MSK_LSB = UADDR_W - MSK_W;  // Compare the top address bits
   localparam int EMS_W = 16;                 // One mode register image
   localparam int EMS_N = 4;                  // Mode register images held
   localparam int EMS_AW = 2;                 // Index width of the images
   localparam logic [3:0] ROW_PINS_RST = 4'h_F;   // Reset row pin count
   localparam logic [3:0] COL_BITS_RST = 4'h_D;   // Reset column bit count
   localparam logic [15:0] MSK_RST = 16'h_7FFF;   // Two chip selects shift
   localparam logic [15:0] VAL_RST = 16'h_0000;   // Reset match value
   localparam int TXSR_NS = 200;                  // Self-refresh exit time
   localparam int CLK_NS = 8;                     // 125 MHz period
   localparam int TXSR_CYC = (TXSR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] TXSR_CNT = 8'(TXSR_CYC);
   localparam int MRW_CYC = 4;                    // Cycles per mode write
   localparam logic [2:0] MRW_CNT = 3'(MRW_CYC);

   typedef enum logic [2:0] {
      DRM_STOPPED = 3'b000,   // Start low, no commands
      DRM_WAIT_INIT = 3'b001, // Waiting for PHY init complete
      DRM_ACTIVE = 3'b010,    // Serving requests
      DRM_SREF = 3'b011,      // Memories in self-refresh
      DRM_SREF_EXIT = 3'b100, // Holding off for exit time
      DRM_MODE_WR = 3'b101    // Sending mode register images
   } drm_state_type;
endpackage

// file: logic/drm_rank_map.sv
// Rank decode and clock change sequencing for the DRAM controller
// How it works
// - Address splits cs, row, bank, column, datapath.
// - Field widths shrink per rank settings.
// - Cs, bank, row, column bits capped at 29.
// - Each rank keeps its own geometry settings.
// - Rank chosen by masked match value compare.
// - Busy output low when idle.
// - Clock enable state reported on status output.
// - Start after change restarts, relocks DLL.
// - Device holds commands for exit time.
// - Mode-write trigger sends mode images out.
// - No commands before PHY init complete.
`timescale 1ns/10ps
module drm_rank_map
   import drm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_srefresh,
   input wire logic i_write_modereg,
   input wire logic i_dfi_init_complete,
   input wire logic [3:0] i_row_pins_0,
   input wire logic [3:0] i_row_pins_1,
   input wire logic [3:0] i_col_bits_0,
   input wire logic [3:0] i_col_bits_1,
   input wire logic i_eight_bank_0,
   input wire logic i_eight_bank_1,
   input wire logic [3:0] i_aprebit_0,
   input wire logic [3:0] i_aprebit_1,
   input wire logic [MSK_W-1:0] i_cs_val_0,
   input wire logic [MSK_W-1:0] i_cs_val_1,
   input wire logic [MSK_W-1:0] i_cs_msk_0,
   input wire logic [MSK_W-1:0] i_cs_msk_1,
   input wire logic i_ems_wr,
   input wire logic [EMS_AW-1:0] i_ems_idx,
   input wire logic [EMS_W-1:0] i_ext_mode_settings,
   input wire logic i_req_valid,
   input wire logic [UADDR_W-1:0] i_req_addr,
   output logic o_req_ready,
   output logic o_cmd_valid,
   output logic [NUM_RANKS-1:0] o_cmd_cs,
   output logic [MAX_ROW-1:0] o_cmd_row,
   output logic [MAX_BANK-1:0] o_cmd_bank,
   output logic [MAX_COL-1:0] o_cmd_col,
   output logic [3:0] o_cmd_aprebit,
   output logic o_cmd_miss,
   output logic o_controller_busy,
   output logic o_cke_status,
   output logic o_dll_relock,
   output logic o_mrw_valid,
   output logic [EMS_AW-1:0] o_mrw_idx,
   output logic [EMS_W-1:0] o_mrw_data
);
   drm_state_type state, next_state;  // Sequencer state
   logic [7:0] wait_cnt, next_wait_cnt;   // Exit hold-off counter
   logic [2:0] mrw_cnt, next_mrw_cnt;     // Cycles per mode write
   logic [EMS_AW-1:0] mrw_idx, next_mrw_idx; // Image being sent
   logic mrw_pend, next_mrw_pend;     // Trigger seen, not yet served
   logic cke, next_cke;               // Memory clock enable
   logic relock, next_relock;         // DLL relock pulse
   logic busy, next_busy;             // Registered busy
   logic mrw_valid, next_mrw_valid;   // Mode write strobe
   logic [EMS_W-1:0] ems_rd;          // Image read data

   // Per-rank geometry as arrays for the generate loop
   logic [3:0] row_pins [NUM_RANKS];
   logic [3:0] col_bits [NUM_RANKS];
   logic eight_bank [NUM_RANKS];
   logic [3:0] aprebit [NUM_RANKS];
   logic [MSK_W-1:0] cs_val [NUM_RANKS];
   logic [MSK_W-1:0] cs_msk [NUM_RANKS];
   logic [NUM_RANKS-1:0] hit;            // Rank matches
   logic [MAX_ROW-1:0] f_row [NUM_RANKS];
   logic [MAX_BANK-1:0] f_bank [NUM_RANKS];
   logic [MAX_COL-1:0] f_col [NUM_RANKS];

   assign row_pins[0] = i_row_pins_0;
   assign row_pins[1] = i_row_pins_1;
   assign col_bits[0] = i_col_bits_0;
   assign col_bits[1] = i_col_bits_1;
   assign eight_bank[0] = i_eight_bank_0;
   assign eight_bank[1] = i_eight_bank_1;
   assign aprebit[0] = i_aprebit_0;
   assign aprebit[1] = i_aprebit_1;
   assign cs_val[0] = i_cs_val_0;
   assign cs_val[1] = i_cs_val_1;
   assign cs_msk[0] = i_cs_msk_0;
   assign cs_msk[1] = i_cs_msk_1;

   // Per rank match and field split
   for (genvar r = 0; r < NUM_RANKS; r++) begin : g_rank
      logic [ADDR_W-1:0] a;  // Address above the datapath bits
      logic [4:0] bank_sh;   // Column plus bank width
      logic [1:0] bank_w;    // Bank bits in use
      assign a = i_req_addr[DP_W +: ADDR_W];
      assign bank_w = eight_bank[r] ? 2'd3 : 2'd2;
      assign bank_sh = 5'(col_bits[r]) + 5'(bank_w);
      // Masked compare against the rank's value
      // Mask ones cover the rank's own span, so only zeros are compared;
      // an all-ones mask then lets a single rank take every address
      assign hit[r] = ((i_req_addr[MSK_LSB +: MSK_W] ^ cs_val[r])
                       & ~cs_msk[r]) == 16'h_0000;
      // Column then bank then row, sized per rank
      assign f_col[r] = MAX_COL'(a & ((ADDR_W'(1) << col_bits[r]) - 1'b1));
      assign f_bank[r] = MAX_BANK'((a >> col_bits[r])
                          & ((ADDR_W'(1) << bank_w) - 1'b1));
      assign f_row[r] = MAX_ROW'((a >> bank_sh)
                          & ((ADDR_W'(1) << row_pins[r]) - 1'b1));
   end

   // Decode pipeline register, lowest matching rank wins
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_cmd_valid <= 1'b0;
         o_cmd_cs <= 2'b00;
         o_cmd_row <= '0;
         o_cmd_bank <= '0;
         o_cmd_col <= '0;
         o_cmd_aprebit <= 4'h_0;
         o_cmd_miss <= 1'b0;
      end else begin
         // Only while active and exit time done
         o_cmd_valid <= i_req_valid && state == DRM_ACTIVE && hit != 2'b00;
         o_cmd_miss <= i_req_valid && state == DRM_ACTIVE && hit == 2'b00;
         if (hit[0]) begin
            o_cmd_cs <= 2'b01;
            o_cmd_row <= f_row[0];
            o_cmd_bank <= f_bank[0];
            o_cmd_col <= f_col[0];
            o_cmd_aprebit <= aprebit[0];
         end else if (hit[1]) begin
            o_cmd_cs <= 2'b10;
            o_cmd_row <= f_row[1];
            o_cmd_bank <= f_bank[1];
            o_cmd_col <= f_col[1];
            o_cmd_aprebit <= aprebit[1];
         end else begin
            o_cmd_cs <= 2'b00;
         end
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_mrw_cnt = mrw_cnt;
      next_mrw_idx = mrw_idx;
      next_cke = cke;
      next_relock = 1'b0;
      next_mrw_valid = 1'b0;
      // Trigger is remembered even mid-sequence
      next_mrw_pend = mrw_pend | i_write_modereg;
      case (state)
         DRM_STOPPED: begin
            if (i_start) begin
               next_state = DRM_WAIT_INIT;
               next_relock = 1'b1;
            end
         end
         DRM_WAIT_INIT: begin
            if (!i_start) begin
               next_state = DRM_STOPPED;
            end else if (i_dfi_init_complete) begin
               // Memories still asleep take the exit path
               next_state = (i_srefresh || !cke) ? DRM_SREF : DRM_ACTIVE;
            end
         end
         DRM_ACTIVE: begin
            if (!i_start) begin
               next_state = DRM_STOPPED;
            end else if (i_srefresh && !i_req_valid) begin
               next_state = DRM_SREF;
               next_cke = 1'b0;
            end else if (mrw_pend && !i_req_valid) begin
               next_state = DRM_MODE_WR;
               next_mrw_idx = '0;
               next_mrw_cnt = MRW_CNT;
               next_mrw_pend = i_write_modereg;
            end
         end
         DRM_SREF: begin
            next_cke = 1'b0;
            if (!i_start) begin
               // Stopped in self-refresh, clock may change
               next_state = DRM_STOPPED;
            end else if (!i_srefresh && i_dfi_init_complete) begin
               next_state = DRM_SREF_EXIT;
               next_cke = 1'b1;
               next_wait_cnt = TXSR_CNT;
            end
         end
         DRM_SREF_EXIT: begin
            // Commands held off while this counts
            if (wait_cnt == 8'h_01) begin
               next_state = DRM_ACTIVE;
            end
            next_wait_cnt = wait_cnt - 8'h_01;
         end
         DRM_MODE_WR: begin
            // One image per MRW_CNT cycles
            next_mrw_cnt = mrw_cnt - 3'h_1;
            if (mrw_cnt == 3'h_1) begin
               next_mrw_valid = 1'b1;
               next_mrw_cnt = MRW_CNT;
               next_mrw_idx = mrw_idx + 1'b1;
               if (mrw_idx == EMS_AW'(EMS_N - 1)) begin
                  next_state = DRM_ACTIVE;
               end
            end
         end
         default: begin
            next_state = DRM_STOPPED;
         end
      endcase
      // Busy while traffic or sequence work is under way
      next_busy = (next_state == DRM_MODE_WR) || i_req_valid ||
                  (next_state == DRM_SREF_EXIT) || next_mrw_pend;
   end

   // Sequencer registers; memories start out in self-refresh off, cke high
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state <= DRM_STOPPED;
         wait_cnt <= 8'h_00;
         mrw_cnt <= 3'h_0;
         mrw_idx <= '0;
         mrw_pend <= 1'b0;
         cke <= 1'b1;
         relock <= 1'b0;
         busy <= 1'b0;
         mrw_valid <= 1'b0;
         o_mrw_idx <= '0;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         mrw_cnt <= next_mrw_cnt;
         mrw_idx <= next_mrw_idx;
         mrw_pend <= next_mrw_pend;
         cke <= next_cke;
         relock <= next_relock;
         busy <= next_busy;
         mrw_valid <= next_mrw_valid;
         o_mrw_idx <= mrw_idx;
      end
   end

   // Image store; read data is registered inside
   drm_ems_mem u_ems (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(i_ems_wr),
      .i_wr_addr(i_ems_idx),
      .i_wr_data(i_ext_mode_settings),
      .i_rd_addr(mrw_idx),
      .o_rd_data(ems_rd)
   );

   // Outputs straight from flip-flops
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_mrw_data <= 16'h_0000;
         o_req_ready <= 1'b0;
      end else begin
         o_mrw_data <= ems_rd;
         o_req_ready <= next_state == DRM_ACTIVE;
      end
   end

   assign o_controller_busy = busy;
   assign o_cke_status = cke;
   assign o_dll_relock = relock;
   assign o_mrw_valid = mrw_valid;
endmodule // drm_rank_map

// file: test/drm_phy_model.sv
// PHY stand-in: reports init complete some cycles after start
`timescale 1ns/10ps
module drm_phy_model (
   input wire logic i_sys_clk,
   input wire logic i_start,
   input wire logic i_slow,
   output logic o_init_complete
);
   logic [7:0] wait_cnt; // Cycles since start rose, cleared while stopped

   // Ready only after a lock time; slow mode stretches it
   always_ff @(posedge i_sys_clk) begin
      if (!i_start) begin
         wait_cnt <= 8'h_00;
         o_init_complete <= 1'b0;
      end else begin
         if (wait_cnt != 8'h_FF) begin
            wait_cnt <= wait_cnt + 8'h_01;
         end
         o_init_complete <= wait_cnt >= (i_slow ? 8'h_40 : 8'h_04);
      end
   end
endmodule // drm_phy_model

// file: test/drm_rank_map_chk.sv
// Port timing checker for the rank decode and clock change block
`timescale 1ns/10ps
module drm_rank_map_chk
   import drm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_srefresh,
   input wire logic i_req_valid,
   input wire logic o_req_ready,
   input wire logic o_cmd_valid,
   input wire logic [NUM_RANKS-1:0] o_cmd_cs,
   input wire logic o_cmd_miss,
   input wire logic o_cke_status,
   input wire logic o_dll_relock,
   input wire logic o_mrw_valid
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   req_answer_a:
      assert property (i_req_valid && o_req_ready |=> o_cmd_valid ^ o_cmd_miss)
      else $error("Request not answered");
   no_stray_cmd_a:
      assert property (!(i_req_valid && o_req_ready)
                       |=> !(o_cmd_valid || o_cmd_miss))
      else $error("Command without request");
   cs_onehot_a:
      assert property (o_cmd_valid |-> $onehot(o_cmd_cs))
      else $error("Chip select not one-hot");
   stopped_idle_a:
      assert property (!i_start |=> !o_req_ready)
      else $error("Ready while stopped");
   sref_no_req_a:
      assert property (!o_cke_status |-> !o_req_ready)
      else $error("Ready during self-refresh");
   cke_cause_a:
      assert property ($fell(o_cke_status) |-> $past(i_srefresh))
      else $error("Clock enable dropped unasked");
   exit_hold_a:
      assert property ($rose(o_cke_status) |-> (!o_req_ready) [*8])
      else $error("Exit time not held");
   exit_bound_a:
      assert property ($rose(o_cke_status) |-> ##[1:40] o_req_ready)
      else $error("Exit wait too long");
   relock_pulse_a:
      assert property ($rose(i_start) |-> ##[1:3] o_dll_relock)
      else $error("No relock after start");
   mrw_space_a:
      assert property (o_mrw_valid |=> (!o_mrw_valid) [*3])
      else $error("Mode writes too close");

   // Main scenarios reached
   cover property (o_cmd_valid && o_cmd_cs[1]);
   cover property (o_cmd_miss);
   cover property (o_mrw_valid);
endmodule // drm_rank_map_chk

// file: test/tb_drm_rank_map.sv
// Random and corner test bench of the rank decode and clock change block
`timescale 1ns/10ps
module tb_drm_rank_map import drm_pkg::*;;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, slow = 1'b0;
   logic i_srefresh = 1'b0, i_write_modereg = 1'b0, i_ems_wr = 1'b0;
   logic i_req_valid = 1'b0, i_dfi_init_complete;
   logic [3:0] row[2], col[2], apb[2]; // Rank geometry
   logic eb[2]; // Eight bank per rank
   logic [15:0] msk[2], val[2]; // Rank match settings
   logic [1:0] i_ems_idx = 2'h_0, o_cmd_cs, o_mrw_idx;
   logic [15:0] i_ext_mode_settings = 16'h_0000, o_mrw_data;
   logic [30:0] i_req_addr = 31'h_0000_0000;
   logic o_req_ready, o_cmd_valid, o_cmd_miss, o_controller_busy;
   logic o_cke_status, o_dll_relock, o_mrw_valid;
   logic [14:0] o_cmd_row;
   logic [2:0] o_cmd_bank;
   logic [12:0] o_cmd_col;
   logic [3:0] o_cmd_aprebit;
   int fail_count = 0, num_checks = 0, relocks = 0, cmds = 0, n;

   always #4 i_sys_clk = ~i_sys_clk;

   drm_rank_map i_dut (.i_sys_clk, .i_rst_n, .i_start, .i_srefresh,
      .i_write_modereg, .i_dfi_init_complete, .i_row_pins_0(row[0]),
      .i_row_pins_1(row[1]), .i_col_bits_0(col[0]), .i_col_bits_1(col[1]),
      .i_eight_bank_0(eb[0]), .i_eight_bank_1(eb[1]), .i_aprebit_0(apb[0]),
      .i_aprebit_1(apb[1]), .i_cs_val_0(val[0]), .i_cs_val_1(val[1]),
      .i_cs_msk_0(msk[0]), .i_cs_msk_1(msk[1]), .i_ems_wr, .i_ems_idx,
      .i_ext_mode_settings, .i_req_valid, .i_req_addr, .o_req_ready,
      .o_cmd_valid, .o_cmd_cs, .o_cmd_row, .o_cmd_bank, .o_cmd_col,
      .o_cmd_aprebit, .o_cmd_miss, .o_controller_busy, .o_cke_status,
      .o_dll_relock, .o_mrw_valid, .o_mrw_idx, .o_mrw_data);
   drm_phy_model i_phy (.i_sys_clk, .i_start, .i_slow(slow),
      .o_init_complete(i_dfi_init_complete));

   // Event counters; registered outputs so edge sampling is safe
   always @(posedge i_sys_clk) begin
      relocks += 32'(o_dll_relock);
      cmds += 32'(o_cmd_valid | o_cmd_miss);
   end

   task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Fields are not compared on a miss: their value there is unspecified
   task automatic chk_cmd(input logic [39:0] exp);
      logic [39:0] got;
      got = {1'b0, o_cmd_valid, o_cmd_miss, o_cmd_aprebit, o_cmd_cs,
         o_cmd_row, o_cmd_bank, o_cmd_col};
      if (exp[37]) got[36:0] = 37'h_0;
      chk_val(got, exp);
   endtask

   // Expected decode; the loop runs down so rank 0 wins a double hit
   function automatic logic [39:0] dec(input logic [30:0] a);
      logic [30:0] s, c, b, w;
      int r;
      r = 2;
      for (int k = 1; k >= 0; k--)
         if (((a[30:15] ^ val[k]) & ~msk[k]) == 16'h_0000) r = k;
      if (r == 2) return 40'h_20_0000_0000;
      s = a >> 2;
      c = s & ((31'h_1 << col[r]) - 31'h_1);
      s = s >> col[r];
      b = s & (eb[r] ? 31'h_7 : 31'h_3);
      s = s >> (eb[r] ? 3 : 2);
      w = s & ((31'h_1 << row[r]) - 31'h_1);
      return {3'b010, apb[r], r == 0 ? 2'b01 : 2'b10, w[14:0], b[2:0], c[12:0]};
   endfunction

   // Mostly inside a rank, sometimes anywhere to reach misses
   function automatic logic [30:0] pick();
      logic [30:0] a;
      int k;
      a = 31'($urandom);
      k = $urandom_range(1);
      if ($urandom_range(3) != 0) a[30:15] = val[k] | (16'($urandom) & msk[k]);
      return a;
   endfunction

   // Geometry within the 29 bit cap, masks and values as software sets them
   task automatic geom();
      logic [3:0] r, c;
      logic e;
      logic [15:0] m[2];
      for (int k = 0; k < 2; k++) begin
         r = 4'(12 + $urandom_range(3));
         e = 1'($urandom_range(1));
         c = 4'(9 + $urandom_range(4));
         if (r + c + (e ? 3 : 2) > 28) c = 4'(28 - r - (e ? 3 : 2));
         m[k] = 16'h_7FFF >> (15 - r + 13 - c + (e ? 0 : 1));
         row[k] <= r;
         col[k] <= c;
         eb[k] <= e;
         apb[k] <= 4'($urandom);
         msk[k] <= m[k];
      end
      val[0] <= m[0] >= m[1] ? 16'h_0000 : m[1] + 16'h_0001;
      val[1] <= m[0] >= m[1] ? m[0] + 16'h_0001 : 16'h_0000;
   endtask

   task automatic wait_for(ref logic s, input logic v);
      int j; // Own count, so the caller's n survives the wait
      for (j = 0; j < 200 && s !== v; j++) begin
         @(posedge i_sys_clk);
         #1;
      end
      chk_val(40'(s), 40'(v));
   endtask

   // Back-to-back requests, each checked one cycle after it is taken
   task automatic run(input int cnt, input string name);
      logic [30:0] q[$];
      logic [30:0] a;
      for (int i = 0; i <= cnt; i++) begin
         @(posedge i_sys_clk);
         a = pick();
         i_req_valid <= 1'(i < cnt);
         i_req_addr <= a;
         q.push_back(a);
         #1;
         if (i > 0) chk_cmd(dec(q.pop_front()));
      end
      $display("test %s done", name);
   endtask

   task automatic modew();
      logic [15:0] img[4];
      for (int i = 0; i < 4; i++) begin
         img[i] = 16'($urandom);
         @(posedge i_sys_clk);
         i_ems_wr <= 1'b1;
         i_ems_idx <= 2'(i);
         i_ext_mode_settings <= img[i];
      end
      @(posedge i_sys_clk);
      i_ems_wr <= 1'b0;
      i_write_modereg <= 1'b1;
      @(posedge i_sys_clk);
      i_write_modereg <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wait_for(o_mrw_valid, 1'b1);
         chk_val({22'h_0, o_mrw_idx, o_mrw_data}, {22'h_0, 2'(i), img[i]});
         // Step past the strobe's edge so the old pulse is not seen again
         @(posedge i_sys_clk);
         #1;
      end
      $display("test mode write done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(8 * 20000);
      fail_count++;
      results();
   end

   initial begin
      void'($urandom(32'h_8184_4f6d));
      geom();
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      #1;
      chk_val({34'h_0, o_req_ready, o_cmd_valid, o_controller_busy,
         o_cke_status, o_dll_relock, o_mrw_valid}, 40'h_4);
      @(posedge i_sys_clk) i_start <= 1'b1;
      wait_for(o_req_ready, 1'b1);
      chk_val(40'(relocks), 40'h_1);
      run(60, "decode");
      modew();
      wait_for(o_controller_busy, 1'b0);
      @(posedge i_sys_clk) i_srefresh <= 1'b1;
      wait_for(o_cke_status, 1'b0);
      n = cmds;
      @(posedge i_sys_clk) i_req_valid <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      i_req_valid <= 1'b0;
      @(posedge i_sys_clk) i_start <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      geom();
      slow <= 1'b1;
      @(posedge i_sys_clk) i_start <= 1'b1;
      chk_val(40'(cmds - n), 40'h_0);
      wait_for(i_dfi_init_complete, 1'b1);
      chk_val(40'(cmds - n), 40'h_0);
      chk_val(40'(relocks), 40'h_2);
      @(posedge i_sys_clk) i_srefresh <= 1'b0;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end while (o_req_ready !== 1'b1 && n < 100);
      chk_val(40'(n >= TXSR_CYC && n <= TXSR_CYC + 3), 40'h_1);
      $display("test clock change done");
      run(60, "restart");
      msk[1] <= msk[0];
      val[1] <= val[0];
      run(20, "double hit");
      results();
   end
endmodule // tb_drm_rank_map

bind drm_rank_map drm_rank_map_chk i_chk (.i_sys_clk, .i_rst_n, .i_start,
   .i_srefresh, .i_req_valid, .o_req_ready, .o_cmd_valid, .o_cmd_cs,
   .o_cmd_miss, .o_cke_status, .o_dll_relock, .o_mrw_valid);
